// *** cpdcs_host.sv ***
// controller end: AXI4-Lite registers, step sequencer, bus clock
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
module cpdcs_host
  import cpdcs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             irq,
  cpdcs_link_if.mgr        lk
);
  if (BUS_HALF_CYC < 1 || BUS_HALF_CYC > 255) $error("bad bus divider");
  if (FRAME_CLKS < 2 || FRAME_CLKS > 15) $error("bad frame length");

  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  data;
    logic [7:0]  mask;
  } cpdcs_step_t;

  typedef struct packed {
    cpdcs_hst_t  st;
    logic        req;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdat;
    logic        busClk;
    logic        frameSync;
    logic        halted;
    logic        armed;
    logic        lastFrame;
    logic [7:0]  divCnt;
    logic [3:0]  bitCnt;
    logic [7:0]  shadow;
    logic [7:0]  pAddr;
    logic [7:0]  pData;
    logic [2:0]  irqSt;
    logic [2:0]  irqMask;
    logic        irqOut;
    logic        awready;
    logic        wready;
    logic        awGot;
    logic        wGot;
    logic [7:0]  awAddr;
    logic [7:0]  wByte;
    logic        wLane;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } cpdcs_host_t;
  cpdcs_host_t s;
  cpdcs_host_t next_s;
  cpdcs_step_t stp;
  logic [2:0]  irqSet;
  logic [3:0]  nextBit;

  // one step of the fixed order per state
  function automatic cpdcs_step_t stepOf(input cpdcs_hst_t h,
                                         input logic [7:0] pa,
                                         input logic [7:0] sh);
    case (h)
      S_CLAMP:  stepOf = '{1'b0, A_CLAMP, V_CLAMP_OFF, 8'hff};
      S_PORT:   stepOf = '{1'b0, A_PDC2, V_PDC2_OFF, 8'hff};
      S_CODEC:  stepOf = '{1'b0, A_PDC1, V_PDC1_OFF, 8'hff};
      S_PDPOLL: stepOf = '{1'b1, A_EVT_STAT, V_PD_DONE, 8'hff};
      S_DISCH:  stepOf = '{1'b0, A_PDC2, V_PDC2_DIS, 8'hff};
      S_OSC:    stepOf = '{1'b0, A_OSC_CTRL, V_OSC_RCO, 8'hff};
      S_OSCPOL: stepOf = '{1'b1, A_OSC_STAT, V_OSC_DONE, 8'hff};
      S_PREP:   stepOf = '{1'b0, A_SYS_CTRL, V_PREPARE, 8'hff};
      S_NFPOLL: stepOf = '{1'b1, A_BUS_CTRL, 8'h00, M_NOT_FIN};
      S_STOP:   stepOf = '{1'b0, A_BUS_CTRL, V_STOP_NOW, 8'hff};
      S_PCLR:   stepOf = '{1'b0, A_PDC2, sh & M_PROT_OFF, 8'hff};
      S_PEN:    stepOf = '{1'b0, A_PAGE_EN, V_PAGE_EN, 8'hff};
      S_PRD:    stepOf = '{1'b1, {PROT_PAGE, pa}, 8'h00, 8'h00};
      default:  stepOf = '{1'b0, 16'h0000, 8'h00, 8'h00};
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == H_CMD) || (a == H_STAT) || (a == H_IRQ) ||
             (a == H_MASK) || (a == H_PADDR) || (a == H_PDATA);
  endfunction

  assign nextBit = (s.bitCnt == 4'(FRAME_CLKS - 1)) ? 4'h0 :
                   s.bitCnt + 4'h1;

  always_comb begin
    next_s = s;
    irqSet = 3'h0;
    stp = stepOf(s.st, s.pAddr, s.shadow);

    // link steps: a poll repeats until the value matches
    if (s.st != S_IDLE && s.st != S_WAIT) begin
      if (!s.req && !lk.ack) begin
        next_s.req = 1'b1;
        next_s.wr = !stp.rd;
        next_s.addr = stp.addr;
        next_s.wdat = stp.data;
      end else if (s.req && lk.ack) begin
        next_s.req = 1'b0;
        if (s.wr || ((lk.rdata & stp.mask) == stp.data)) begin
          if (s.wr && s.addr == A_PDC2) begin
            next_s.shadow = s.wdat;
          end
          if (s.st == S_PRD) begin
            next_s.pData = lk.rdata;
            irqSet[IRQ_PREAD_BIT] = 1'b1;
            next_s.st = S_IDLE;
          end else if (s.st == S_STOP) begin
            next_s.armed = 1'b1;
            next_s.st = S_WAIT;
          end else begin
            next_s.st = cpdcs_hst_t'(s.st + 4'h1);
          end
        end
      end
    end
    if (s.st == S_WAIT && s.halted) begin
      irqSet[IRQ_SEQ_BIT] = 1'b1;
      irqSet[IRQ_STOP_BIT] = 1'b1;
      next_s.st = S_IDLE;
    end

    // bus clock divider; one whole frame runs after stop-now
    if (!s.halted) begin
      if (s.divCnt == 8'(BUS_HALF_CYC - 1)) begin
        next_s.divCnt = 8'h00;
        if (s.busClk) begin
          next_s.busClk = 1'b0;
        end else if (nextBit == 4'h0 && s.lastFrame) begin
          next_s.halted = 1'b1;
          next_s.lastFrame = 1'b0;
          next_s.frameSync = 1'b0;
        end else begin
          next_s.busClk = 1'b1;
          next_s.bitCnt = nextBit;
          next_s.frameSync = (nextBit == 4'h0);
          // a stop acked on a frame start makes that frame the last
          if (nextBit == 4'h0 && next_s.armed) begin
            next_s.lastFrame = 1'b1;
            next_s.armed = 1'b0;
          end
        end
      end else begin
        next_s.divCnt = s.divCnt + 8'h01;
      end
    end

    // AXI4-Lite write: address and data in either order
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (awvalid && s.awready) begin
      next_s.awGot = 1'b1;
      next_s.awAddr = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.wGot = 1'b1;
      next_s.wByte = wdata[7:0];
      next_s.wLane = wstrb[0];
    end
    if (s.awGot && s.wGot && !s.bvalid) begin
      next_s.awGot = 1'b0;
      next_s.wGot = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = mapped(s.awAddr) ? RESP_OKAY : RESP_DECERR;
      if (s.wLane) begin
        case (s.awAddr)
          H_CMD: begin
            // commands while busy are dropped
            if (s.st == S_IDLE && s.wByte[CMD_SEQ_BIT]) begin
              next_s.st = S_CLAMP;
              next_s.lastFrame = 1'b0;
              next_s.armed = 1'b0;
              // a running clock keeps its phase, so no phase is cut short
              if (s.halted) begin
                next_s.halted = 1'b0;
                next_s.divCnt = 8'h00;
                next_s.bitCnt = 4'(FRAME_CLKS - 1);
              end
            end else if (s.st == S_IDLE && s.wByte[CMD_PREAD_BIT]) begin
              next_s.st = S_PCLR;
            end
          end
          H_IRQ:   next_s.irqSt = s.irqSt & ~s.wByte[2:0];
          H_MASK:  next_s.irqMask = s.wByte[2:0];
          H_PADDR: next_s.pAddr = s.wByte;
          default: ;
        endcase
      end
    end
    next_s.awready = !next_s.awGot;
    next_s.wready = !next_s.wGot;

    // AXI4-Lite read
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = mapped(araddr) ? RESP_OKAY : RESP_DECERR;
      case (araddr)
        H_STAT:  next_s.rdata = {27'h0, s.st != S_IDLE, s.st};
        H_IRQ:   next_s.rdata = {29'h0, s.irqSt};
        H_MASK:  next_s.rdata = {29'h0, s.irqMask};
        H_PADDR: next_s.rdata = {24'h0, s.pAddr};
        H_PDATA: next_s.rdata = {24'h0, s.pData};
        default: next_s.rdata = 32'h0;
      endcase
    end
    next_s.arready = !next_s.rvalid;

    // a new event beats a clear in the same cycle
    next_s.irqSt = next_s.irqSt | irqSet;
    next_s.irqOut = |(next_s.irqSt & next_s.irqMask);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= S_IDLE;
      s.shadow <= PDC2_RST;
      s.bitCnt <= 4'(FRAME_CLKS - 1);
    end else begin
      s <= next_s;
    end
  end

  assign lk.busClk    = s.busClk;
  assign lk.frameSync = s.frameSync;
  assign lk.req       = s.req;
  assign lk.wr        = s.wr;
  assign lk.addr      = s.addr;
  assign lk.wdata     = s.wdat;
  assign awready      = s.awready;
  assign wready       = s.wready;
  assign bvalid       = s.bvalid;
  assign bresp        = s.bresp;
  assign arready      = s.arready;
  assign rvalid       = s.rvalid;
  assign rdata        = s.rdata;
  assign rresp        = s.rresp;
  assign irq          = s.irqOut;
endmodule

// *** cpdcs_pkg.sv ***
// constants, types and register map of the codec power-down sequencer
package cpdcs_pkg;
  // device map, one byte per address
  localparam logic [15:0] A_BUS_CTRL  = 16'h0044;
  localparam logic [15:0] A_SYS_CTRL  = 16'h0045;
  localparam logic [15:0] A_PDC1      = 16'h1101;
  localparam logic [15:0] A_PDC2      = 16'h1102;
  localparam logic [15:0] A_OSC_CTRL  = 16'h1107;
  localparam logic [15:0] A_OSC_STAT  = 16'h1109;
  localparam logic [15:0] A_EVT_STAT  = 16'h1308;
  localparam logic [15:0] A_PAGE_EN   = 16'h1801;
  localparam logic [15:0] A_CLAMP     = 16'h1f01;
  localparam logic [7:0]  PROT_PAGE   = 8'h30;
  // values the sequence writes or waits for
  localparam logic [7:0]  V_CLAMP_OFF = 8'h01;
  localparam logic [7:0]  V_PDC2_OFF  = 8'h8c;
  localparam logic [7:0]  V_PDC1_OFF  = 8'hff;
  localparam logic [7:0]  V_PD_DONE   = 8'h01;
  localparam logic [7:0]  V_PDC2_DIS  = 8'h9c;
  localparam logic [7:0]  V_OSC_RCO   = 8'h00;
  localparam logic [7:0]  V_OSC_DONE  = 8'h05;
  localparam logic [7:0]  V_PREPARE   = 8'h01;
  localparam logic [7:0]  V_STOP_NOW  = 8'h02;
  localparam logic [7:0]  V_PAGE_EN   = 8'h01;
  localparam logic [7:0]  M_NOT_FIN   = 8'h01;
  localparam logic [7:0]  M_PROT_OFF  = 8'h7f;
  // field positions
  localparam int PDC1_ALL_BIT  = 0;
  localparam int PDC2_PROT_BIT = 7;
  localparam int PDC2_DIS_BIT  = 4;
  localparam int PDC2_OVR_BIT  = 3;
  localparam int PDC2_PORT_BIT = 2;
  localparam int PDC2_PLAY_BIT = 1;
  localparam int PDC2_CAP_BIT  = 0;
  localparam int OSC_PRES_BIT  = 0;
  localparam int SYS_PREP_BIT  = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int PAGE_EN_BIT   = 0;
  localparam logic [1:0] SEL_SCLK = 2'h0;
  localparam logic [1:0] SEL_RCO  = 2'h1;
  localparam logic [1:0] SEL_PLL  = 2'h2;
  // reset values
  localparam logic [7:0] PDC1_RST = 8'h00;
  localparam logic [7:0] PDC2_RST = 8'h83;
  localparam logic [7:0] OSC_RST  = 8'h01;
  // timing
  localparam int CLK_MHZ        = 250;
  localparam int PLL_SETTLE_MS  = 1;
  localparam int PLL_SETTLE_CYC = PLL_SETTLE_MS * 1000 * CLK_MHZ;
  localparam int PD_SETTLE_NS   = 80;
  localparam int PD_SETTLE_CYC  = (PD_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int OSC_SW_NS      = 40;
  localparam int OSC_SW_CYC     = (OSC_SW_NS * CLK_MHZ + 999) / 1000;
  localparam int BUS_PERIOD_NS  = 160;
  localparam int BUS_HALF_CYC   = BUS_PERIOD_NS * CLK_MHZ / 2000;
  localparam int FRAME_CLKS     = 8;
  // controller registers, byte addresses on the AXI4-Lite side
  localparam logic [7:0] H_CMD   = 8'h00;
  localparam logic [7:0] H_STAT  = 8'h04;
  localparam logic [7:0] H_IRQ   = 8'h08;
  localparam logic [7:0] H_MASK  = 8'h0c;
  localparam logic [7:0] H_PADDR = 8'h10;
  localparam logic [7:0] H_PDATA = 8'h14;
  localparam int CMD_SEQ_BIT   = 0;
  localparam int CMD_PREAD_BIT = 1;
  localparam int IRQ_SEQ_BIT   = 0;
  localparam int IRQ_PREAD_BIT = 1;
  localparam int IRQ_STOP_BIT  = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [3:0] {
    S_IDLE   = 4'b0000,
    S_CLAMP  = 4'b0001,
    S_PORT   = 4'b0010,
    S_CODEC  = 4'b0011,
    S_PDPOLL = 4'b0100,
    S_DISCH  = 4'b0101,
    S_OSC    = 4'b0110,
    S_OSCPOL = 4'b0111,
    S_PREP   = 4'b1000,
    S_NFPOLL = 4'b1001,
    S_STOP   = 4'b1010,
    S_WAIT   = 4'b1011,
    S_PCLR   = 4'b1100,
    S_PEN    = 4'b1101,
    S_PRD    = 4'b1110
  } cpdcs_hst_t;
endpackage

// *** cpdcs_link_if.sv ***
// link between sequencing controller and codec register port
`timescale 1ns/10ps
interface cpdcs_link_if;
  logic        busClk;
  logic        frameSync;
  logic        req;
  logic        wr;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        ack;
  logic [7:0]  rdata;
  modport mgr (
    output busClk, frameSync, req, wr, addr, wdata,
    input  ack, rdata
  );
  modport dev (
    input  busClk, frameSync, req, wr, addr, wdata,
    output ack, rdata
  );
endinterface

// *** cpdcs_sync.sv ***
// two-flop synchroniser with rising-edge detect
`timescale 1ns/10ps
module cpdcs_sync #(
  parameter int W = 2
)(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } cpdcs_sync_t;
  cpdcs_sync_t s;
  cpdcs_sync_t next_s;

  if (W < 1) $error("cpdcs_sync width must be at least one");

  always_comb begin
    next_s = '{s1: async, s2: s.s1, s3: s.s2};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // edge detect looks only at settled stages
  assign level = s.s2;
  assign rise  = s.s2 & ~s.s3;
endmodule

// *** cpdcs_device.sv ***
// codec end: register port, power-down status, clock switch, clock stop
`timescale 1ns/10ps
module cpdcs_device
  import cpdcs_pkg::*;
#(
  parameter int         PLL_SETTLE = PLL_SETTLE_CYC,
  parameter logic [7:0] PROT_VALUE = 8'h5a  // arbitrary
)(
  input  wire logic       clk,
  input  wire logic       rst_n,
  cpdcs_link_if.dev       lk,
  input  wire logic       pllNeeded,
  input  wire logic       hsDetectOn,
  input  wire logic       hsDetectDone,
  output logic [7:0]      codecPathOff,
  output logic            portOff,
  output logic            rateConvOff,
  output logic            filterDischarge,
  output logic            pllEnable,
  output logic [1:0]      mclkSel,
  output logic            headsetClampOff,
  output logic            clockStopped
);
  localparam int PW = $clog2(PLL_SETTLE + 1);

  if (PLL_SETTLE < 1) $error("PLL_SETTLE must be at least one");
  if (PD_SETTLE_CYC > 255 || OSC_SW_CYC > 255) $error("timer too long");

  typedef struct packed {
    logic [7:0]    pdc1;
    logic [7:0]    pdc2;
    logic [7:0]    oscCtrl;
    logic [7:0]    sysCtrl;
    logic [7:0]    pageEn;
    logic [7:0]    clamp;
    logic [7:0]    rdata;
    logic          ack;
    logic          pdDone;
    logic          oscPwr;
    logic [1:0]    sel;
    logic          notFin;
    logic          stopNow;
    logic          counting;
    logic          stopped;
    logic          pllEn;
    logic          reference_filter_node;
    logic [7:0]    pdCnt;
    logic [7:0]    oscCnt;
    logic [PW-1:0] pllCnt;
    logic [3:0]    bitCnt;
    logic [2:0]    stopDly;
  } cpdcs_dev_t;
  cpdcs_dev_t s;
  cpdcs_dev_t next_s;
  logic [1:0] linkLvl;
  logic [1:0] linkRise;

  cpdcs_sync #(.W(2)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .async ({lk.frameSync, lk.busClk}),
    .level (linkLvl),
    .rise  (linkRise)
  );

  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    if (lk.req && !s.ack) begin
      next_s.ack = 1'b1;
      next_s.rdata = 8'h00;
      if (lk.wr) begin
        case (lk.addr)
          A_PDC1:     next_s.pdc1 = lk.wdata;
          A_PDC2:     next_s.pdc2 = lk.wdata;
          A_OSC_CTRL: next_s.oscCtrl = lk.wdata;
          A_PAGE_EN:  next_s.pageEn = lk.wdata;
          A_CLAMP:    next_s.clamp = lk.wdata;
          A_SYS_CTRL: begin
            next_s.sysCtrl = lk.wdata;
            if (lk.wdata[SYS_PREP_BIT] && !s.stopNow) begin
              next_s.notFin = 1'b1;
            end
          end
          A_BUS_CTRL: begin
            // stop-now is refused until the device has reported ready
            if (lk.wdata[CTRL_STOP_BIT] && !s.notFin &&
                s.sysCtrl[SYS_PREP_BIT]) begin
              next_s.stopNow = 1'b1;
            end
          end
          default: ;
        endcase
      end else begin
        case (lk.addr)
          A_PDC1:     next_s.rdata = s.pdc1;
          A_PDC2:     next_s.rdata = s.pdc2;
          A_OSC_CTRL: next_s.rdata = s.oscCtrl;
          A_SYS_CTRL: next_s.rdata = s.sysCtrl;
          A_PAGE_EN:  next_s.rdata = s.pageEn;
          A_CLAMP:    next_s.rdata = s.clamp;
          A_OSC_STAT: next_s.rdata = {5'h00, s.oscPwr, s.sel};
          A_EVT_STAT: begin
            next_s.rdata = {6'h00, hsDetectOn & hsDetectDone,
                            s.pdDone};
          end
          A_BUS_CTRL: next_s.rdata = {6'h00, s.stopNow, s.notFin};
          default: begin
            if (lk.addr[15:8] == PROT_PAGE && !s.pdc2[PDC2_PROT_BIT] &&
                s.pageEn[PAGE_EN_BIT]) begin
              next_s.rdata = PROT_VALUE;
            end
          end
        endcase
      end
    end

    // completion is reported once the global power-down has settled
    if (!s.pdc1[PDC1_ALL_BIT]) begin
      next_s.pdCnt = 8'h00;
      next_s.pdDone = 1'b0;
    end else if (s.pdCnt == 8'(PD_SETTLE_CYC)) begin
      next_s.pdDone = 1'b1;
    end else begin
      next_s.pdCnt = s.pdCnt + 8'h01;
    end

    // discharge only while port and converters stay off
    next_s.reference_filter_node = s.pdc2[PDC2_DIS_BIT] & s.pdc2[PDC2_OVR_BIT] &
                  s.pdc2[PDC2_PORT_BIT] & ~s.pdc2[PDC2_PLAY_BIT] &
                  ~s.pdc2[PDC2_CAP_BIT];

    // pll runs whenever the serial clock is an odd rate
    next_s.pllEn = pllNeeded;
    if (!pllNeeded) begin
      next_s.pllCnt = '0;
    end else if (s.pllCnt != PW'(PLL_SETTLE)) begin
      next_s.pllCnt = s.pllCnt + PW'(1);
    end

    if (s.oscCtrl[OSC_PRES_BIT]) begin
      next_s.oscCnt = 8'h00;
      next_s.oscPwr = 1'b0;
      // bypass until the pll has settled
      next_s.sel = (pllNeeded && s.pllCnt == PW'(PLL_SETTLE)) ?
                   SEL_PLL : SEL_SCLK;
    end else if (s.oscCnt == 8'(OSC_SW_CYC)) begin
      next_s.oscPwr = 1'b1;
      next_s.sel = SEL_RCO;
    end else begin
      next_s.oscCnt = s.oscCnt + 8'h01;
    end

    if (s.notFin && s.pdDone && s.oscPwr && s.sel == SEL_RCO) begin
      next_s.notFin = 1'b0;
    end

    // count the one further frame on the sampled bus clock; the delay
    // covers the sync latency so both ends pick the same frame
    next_s.stopDly = {s.stopDly[1:0], s.stopNow};
    if (s.stopDly[2] && !s.stopped && linkRise[0]) begin
      if (!s.counting && linkLvl[1]) begin
        next_s.counting = 1'b1;
        next_s.bitCnt = 4'h1;
      end else if (s.counting) begin
        next_s.bitCnt = s.bitCnt + 4'h1;
      end
    end
    if (s.counting && s.bitCnt == 4'(FRAME_CLKS)) begin
      next_s.stopped = 1'b1;
      next_s.counting = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
      s.pdc1 <= PDC1_RST;
      s.pdc2 <= PDC2_RST;
      s.oscCtrl <= OSC_RST;
      s.sel <= SEL_SCLK;
    end else begin
      s <= next_s;
    end
  end

  assign lk.ack          = s.ack;
  assign lk.rdata        = s.rdata;
  assign codecPathOff    = s.pdc1;
  assign portOff         = s.pdc2[PDC2_PORT_BIT];
  assign rateConvOff     = s.pdc2[PDC2_OVR_BIT];
  assign filterDischarge = s.reference_filter_node;
  assign pllEnable       = s.pllEn;
  assign mclkSel         = s.sel;
  assign headsetClampOff = s.clamp[0];
  assign clockStopped    = s.stopped;
endmodule

// *** cpdcs_dummy_guard.sv ***
// holds no logic

// *** cpdcs_asserts.sv ***
// link checks between sequencing controller and codec end
`timescale 1ns/10ps
module cpdcs_asserts
  import cpdcs_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        busClk,
  input wire logic        frameSync,
  input wire logic        req,
  input wire logic        wr,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        ack,
  input wire logic [7:0]  rdata
);
  logic       clkQ;
  logic       armed;
  logic [6:0] lowCnt;
  logic [4:0] riseCnt;
  logic       pdSeen;
  wire        busRise = busClk && !clkQ;
  wire        stopAck = ack && wr && addr == A_BUS_CTRL
                        && wdata == V_STOP_NOW;
  // a halt is any low stretch well past the 20-cycle half period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clkQ <= 1'b0;
      armed <= 1'b0;
      lowCnt <= 7'h00;
      riseCnt <= 5'h00;
      pdSeen <= 1'b0;
    end else begin
      clkQ <= busClk;
      if (ack && !wr && addr == A_EVT_STAT && rdata == V_PD_DONE)
        pdSeen <= 1'b1;
      if (busClk)
        lowCnt <= 7'h00;
      else if (lowCnt != 7'h7f)
        lowCnt <= lowCnt + 7'h01;
      if (stopAck) begin
        armed <= 1'b1;
        riseCnt <= 5'h00;
      end else if (busRise && lowCnt > 7'h3c)
        armed <= 1'b0;
      else if (busRise && riseCnt != 5'h1f)
        riseCnt <= riseCnt + 5'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ack_single: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (ack |-> req)
    else $error("ack without request");
  a_req_steady: assert property (req && !ack |=> req && $stable(wr)
    && $stable(addr) && $stable(wdata))
    else $error("request changed before ack");
  a_req_drop: assert property (ack |=> !req)
    else $error("request held after ack");
  a_ack_prompt: assert property ($rose(req) |-> ##[1:2] ack)
    else $error("ack late");
  a_clk_high: assert property ($rose(busClk) |-> busClk[*8])
    else $error("bus clock high phase short");
  a_clk_low: assert property ($fell(busClk) |-> !busClk[*8])
    else $error("bus clock low phase short");
  a_sync_width: assert property ($rose(frameSync) |-> frameSync[*8])
    else $error("frame sync short");
  a_halt_frame: assert property (lowCnt == 7'h3c |-> armed
    && riseCnt >= 5'h08 && riseCnt <= 5'h0f)
    else $error("bus clock halt not one frame after stop");
  a_evt_value: assert property (ack && !wr && addr == A_EVT_STAT
    |-> rdata == 8'h00 || rdata == V_PD_DONE)
    else $error("event status has stray bits");
  a_disch_order: assert property (ack && wr && addr == A_PDC2
    && wdata == V_PDC2_DIS |-> pdSeen)
    else $error("discharge before power-down done");
endmodule

// *** codec_power_down_clock_stop_seq_tb_top.sv ***
// bench joining controller and codec ends over the link
`timescale 1ns/10ps
module codec_power_down_clock_stop_seq_tb_top
  import cpdcs_pkg::*;
;
  localparam int         SETTLE = 16;
  localparam logic [7:0] PVAL   = 8'h5a;  // arbitrary
  logic clk = 1'b0, rst_n = 1'b0, irq, clockStopped;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready;
  logic bvalid, arready, rvalid, portOff, rateConvOff;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, codecPathOff;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, mclkSel;
  logic pllNeeded = 1'b0, hsDetectDone = 1'b0, hsDetectOn = 1'b0;
  logic filterDischarge, pllEnable, headsetClampOff;
  int   errTotal = 0, cmpCount = 0;
  cpdcs_link_if link();
  cpdcs_host cpdcs_host_inst(.clk(clk), .rst_n(rst_n),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .irq(irq), .lk(link));
  cpdcs_device #(.PLL_SETTLE(SETTLE), .PROT_VALUE(PVAL))
    cpdcs_device_inst(.clk(clk), .rst_n(rst_n), .lk(link),
    .pllNeeded(pllNeeded), .hsDetectOn(hsDetectOn),
    .hsDetectDone(hsDetectDone), .codecPathOff(codecPathOff),
    .portOff(portOff), .rateConvOff(rateConvOff),
    .filterDischarge(filterDischarge), .pllEnable(pllEnable),
    .mclkSel(mclkSel), .headsetClampOff(headsetClampOff),
    .clockStopped(clockStopped));
  cpdcs_asserts cpdcs_asserts_inst(.clk(clk), .rst_n(rst_n),
    .busClk(link.busClk), .frameSync(link.frameSync), .req(link.req),
    .wr(link.wr), .addr(link.addr), .wdata(link.wdata),
    .ack(link.ack), .rdata(link.rdata));
  always #2 clk = ~clk;
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmpCount++;
    if (g !== e) begin
      errTotal++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d,
           input logic [3:0] s, input logic [1:0] r);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    for (int i = 0; i < 60 && bvalid !== 1'b1; i++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    chk("bvalid", 32'h1, 32'(bvalid));
    bready <= 1'b0;
    chk("bresp", 32'(r), 32'(bresp));
  endtask
  task axr(input logic [7:0] a, input logic [1:0] r,
           output logic [31:0] d);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (int i = 0; i < 60 && rvalid !== 1'b1; i++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    chk("rvalid", 32'h1, 32'(rvalid));
    d = rdata;
    rready <= 1'b0;
    chk("rresp", 32'(r), 32'(rresp));
  endtask
  task tReset;
    logic [31:0] d;
    chk("mclkSel", 32'(SEL_SCLK), 32'(mclkSel));
    axr(H_STAT, RESP_OKAY, d);
    chk("status", 32'h0, d);
    axr(8'h20, RESP_DECERR, d);
    chk("unmapped", 32'h0, d);
    axw(8'h24, 32'h1, 4'hf, RESP_DECERR);
  endtask
  task tMask;
    logic [31:0] d;
    axw(H_MASK, 32'h5, 4'h0, RESP_OKAY);
    axr(H_MASK, RESP_OKAY, d);
    chk("mask", 32'h0, d);
  endtask
  task tProt;
    logic [31:0] d;
    d = 32'h0;
    axw(H_PADDR, 32'h12, 4'h1, RESP_OKAY);
    axw(H_CMD, 32'h2, 4'h1, RESP_OKAY);
    for (int i = 0; i < 40 && d[IRQ_PREAD_BIT] !== 1'b1; i++)
      axr(H_IRQ, RESP_OKAY, d);
    chk("pread done", 32'h2, d);
    chk("masked irq", 32'h0, 32'(irq));
    axr(H_PDATA, RESP_OKAY, d);
    chk("page data", 32'(PVAL), d);
    axw(H_MASK, 32'h2, 4'h1, RESP_OKAY);
    chk("irq", 32'h1, 32'(irq));
    axw(H_IRQ, 32'h2, 4'h1, RESP_OKAY);
    chk("cleared irq", 32'h0, 32'(irq));
  endtask
  task tPll;
    @(posedge clk);
    pllNeeded <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pllEnable", 32'h1, 32'(pllEnable));
    chk("bypass", 32'(SEL_SCLK), 32'(mclkSel));
    repeat (SETTLE + 8) @(posedge clk);
    chk("pll sel", 32'(SEL_PLL), 32'(mclkSel));
  endtask
  task tSeq;
    logic [31:0] d;
    hsDetectDone <= 1'b1;
    axw(H_MASK, 32'h5, 4'h1, RESP_OKAY);
    axw(H_CMD, 32'h1, 4'h1, RESP_OKAY);
    axw(H_CMD, 32'h1, 4'h1, RESP_OKAY);
    // early polls see detection off, later ones see it unfinished
    repeat (12) @(posedge clk);
    hsDetectOn <= 1'b1;
    hsDetectDone <= 1'b0;
    for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge clk);
    axr(H_IRQ, RESP_OKAY, d);
    chk("irq bits", 32'h5, d);
    chk("codec off", 32'hff, 32'(codecPathOff));
    chk("port off", 32'h1, 32'(portOff));
    chk("conv off", 32'h1, 32'(rateConvOff));
    chk("discharge", 32'h1, 32'(filterDischarge));
    chk("clamp off", 32'h1, 32'(headsetClampOff));
    chk("rc sel", 32'(SEL_RCO), 32'(mclkSel));
    chk("stopped", 32'h1, 32'(clockStopped));
    repeat (100) @(posedge clk);
    chk("bus clock", 32'h0, 32'(link.busClk));
    axw(H_IRQ, 32'h5, 4'h1, RESP_OKAY);
    chk("irq clear", 32'h0, 32'(irq));
  endtask
  task testDone;
    if (errTotal == 0 && cmpCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    tReset();
    tMask();
    tProt();
    tPll();
    tSeq();
    testDone();
  end
  initial begin
    #60000;
    errTotal++;
    testDone();
  end
endmodule
